// file: verilog/pfs_seq.sv
// Fault supervision and VBUS power-path sequencing
`timescale 1ns/1ps
// Overview of operation
// - Overvoltage trip opens gate within 50 us.
// - Discharge on overvoltage until target reached.
// - Blank overvoltage 90 ms on downward steps.
// - Undervoltage opens gate after 30 ms.
// - Overcurrent qualified after 30 ms deglitch.
// - Overcurrent shuts path, requests Hard Reset.
// - Short circuit retries every 0.8 s.
// - Overtemp sets at 140, clears 25 lower.
// - Sleep 3 s after cable detach.
// - CC mode undervoltage: off, start recovery.
// - Supply lockout resets whole device.
// - Cable compensation setting is 0 to 7.
// - Attach order: 5 V, VCONN, then advertise.
// - Init after analog ready; then negotiate.
// - Gate high connects, low disconnects VBUS.
module pfs_seq
   import pfs_pkg::*;
#(
   parameter int OV_BLANK = OV_BLANK_TK,
   parameter int UV_DELAY = UV_DELAY_TK,
   parameter int OC_DEGLITCH = OC_DEGLITCH_TK,
   parameter int SC_RESTART = SC_RESTART_TK,
   parameter int SLEEP_DLY = SLEEP_TK,
   parameter int TICK = TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic analog_ready,
   input wire logic init_done,
   input wire logic supply_lockout,
   input wire logic cc1_attached,
   input wire logic cc2_attached,
   input wire logic [MV_W-1:0] req_mv,
   input wire logic req_valid,
   input wire logic ov_cmp,
   input wire logic undervoltage_guard,
   input wire logic overcurrent_guard,
   input wire logic short_cmp,
   input wire logic at_target,
   input wire logic cc_mode,
   input wire logic [TEMP_W-1:0] temp_c,
   input wire logic [COMP_W-1:0] comp_set,
   input wire logic vconn_checked,
   output logic vbus_switch_gate,
   output logic discharge_en,
   output logic vconn_en,
   output logic advertise_en,
   output logic negotiate_en,
   output logic init_start,
   output logic hard_reset_req,
   output logic overtemp_flag,
   output logic sleep_mode,
   output logic device_reset,
   output logic regulation_drive_output,
   output logic [MV_W-1:0] ov_thresh_mv,
   output logic [MV_W-1:0] uv_thresh_mv,
   output logic [COMP_W-1:0] cable_drop_compensation
);
   // ==================================================================
   // State
   // ==================================================================
   typedef enum {
      ST_POR, ST_INIT, ST_IDLE, ST_VBUS5, ST_VCONN, ST_RUN, ST_FAULT,
      ST_RETRY, ST_SLEEP
   } pfs_st_t;
   typedef struct packed {
      pfs_st_t st;
      logic [TKW-1:0] tick_cnt;
      logic tick;
      logic [2:0] ov_sy;
      logic [2:0] sc_sy;
      logic [MV_W-1:0] cur_mv;
      logic gate;
      logic dis;
      logic vconn;
      logic adv;
      logic neg;
      logic init;
      logic hrst;
      logic ot;
      logic slp;
      logic drst;
      logic reg_drv;
      logic blank;
      logic [MV_W-1:0] ovt;
      logic [MV_W-1:0] uvt;
      logic [COMP_W-1:0] comp;
   } pfs_seq_t;
   pfs_seq_t s_r;
   pfs_seq_t s_nxt;
   logic uv_done;
   logic oc_done;
   logic sc_done;
   logic slp_done;
   logic blank_done;
   logic attached;
   logic ov_sync;
   logic sc_sync;
   logic ov_trip;
   assign attached = cc1_attached | cc2_attached;
   // Only the agreeing second and third stages are looked at
   assign ov_sync = s_r.ov_sy[1] & s_r.ov_sy[2];
   assign sc_sync = s_r.sc_sy[1] & s_r.sc_sy[2];
   assign ov_trip = ov_sync & ~s_r.blank;
   // ==================================================================
   // Qualify timers
   // ==================================================================
   pfs_timer #(.LIMIT(UV_DELAY)) u_uv (.core_clk(core_clk),
      .rst_b(rst_b), .tick(s_r.tick),
      .cond(undervoltage_guard && s_r.st == ST_RUN && !cc_mode),
      .done(uv_done));
   pfs_timer #(.LIMIT(OC_DEGLITCH)) u_oc (.core_clk(core_clk),
      .rst_b(rst_b), .tick(s_r.tick),
      .cond(overcurrent_guard && s_r.st == ST_RUN),
      .done(oc_done));
   pfs_timer #(.LIMIT(SC_RESTART)) u_sc (.core_clk(core_clk),
      .rst_b(rst_b), .tick(s_r.tick), .cond(s_r.st == ST_RETRY),
      .done(sc_done));
   pfs_timer #(.LIMIT(SLEEP_DLY)) u_slp (.core_clk(core_clk),
      .rst_b(rst_b), .tick(s_r.tick),
      .cond(!attached && s_r.st == ST_IDLE),
      .done(slp_done));
   pfs_timer #(.LIMIT(OV_BLANK)) u_blk (.core_clk(core_clk),
      .rst_b(rst_b), .tick(s_r.tick), .cond(s_r.blank),
      .done(blank_done));
   // ==================================================================
   // Next state
   // ==================================================================
   always_comb begin
      s_nxt = s_r;
      s_nxt.ov_sy = {s_r.ov_sy[1:0], ov_cmp};
      s_nxt.sc_sy = {s_r.sc_sy[1:0], short_cmp};
      s_nxt.tick = 1'b0;
      if (s_r.tick_cnt == TKW'(TICK - 1)) begin
         s_nxt.tick_cnt = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
      end
      s_nxt.hrst = 1'b0;
      s_nxt.comp = comp_set;
      s_nxt.reg_drv = s_r.gate & cc_mode;
      // Thresholds scale from the profile actually in force
      s_nxt.ovt = MV_W'(32'(s_r.cur_mv) * OV_PCT / 100);
      s_nxt.uvt = MV_W'(32'(s_r.cur_mv) * UV_PCT / 100);
      // A new downward step wins over the end of the previous window
      if (blank_done) begin
         s_nxt.blank = 1'b0;
      end
      if (req_valid) begin
         s_nxt.cur_mv = req_mv;
         if (req_mv < s_r.cur_mv) begin
            s_nxt.blank = 1'b1;
         end
      end
      if (temp_c >= TEMP_W'(OT_SET_C)) begin
         s_nxt.ot = 1'b1;
      end else if (temp_c <= TEMP_W'(OT_CLR_C)) begin
         s_nxt.ot = 1'b0;
      end
      if (s_r.dis && at_target) begin
         s_nxt.dis = 1'b0;
      end
      case (s_r.st)
         ST_POR: begin
            if (analog_ready) begin
               s_nxt.st = ST_INIT;
               s_nxt.init = 1'b1;
            end
         end
         ST_INIT: begin
            if (init_done) begin
               s_nxt.st = ST_IDLE;
               s_nxt.init = 1'b0;
            end
         end
         ST_IDLE: begin
            if (slp_done) begin
               s_nxt.st = ST_SLEEP;
               s_nxt.slp = 1'b1;
            end else if (attached && !s_r.ot) begin
               s_nxt.st = ST_VBUS5;
               s_nxt.cur_mv = SAFE_MV;
               s_nxt.gate = GATE_ON;
            end
         end
         ST_VBUS5: begin
            s_nxt.st = ST_VCONN;
            s_nxt.vconn = 1'b1;
         end
         ST_VCONN: begin
            if (vconn_checked) begin
               s_nxt.st = ST_RUN;
               s_nxt.adv = 1'b1;
               s_nxt.neg = 1'b1;
            end
         end
         ST_RUN: begin
            if (ov_trip || oc_done || uv_done || s_r.ot || sc_sync ||
                (cc_mode && undervoltage_guard) || !attached) begin
               s_nxt.gate = GATE_OFF;
               s_nxt.adv = 1'b0;
               s_nxt.neg = 1'b0;
               s_nxt.vconn = 1'b0;
               s_nxt.st = sc_sync ? ST_RETRY : ST_FAULT;
               s_nxt.dis = ov_trip;
               s_nxt.hrst = oc_done;
            end
         end
         ST_FAULT: begin
            if (!s_r.dis && !s_r.ot) begin
               s_nxt.st = ST_IDLE;
            end
         end
         ST_RETRY: begin
            if (sc_done) begin
               s_nxt.st = ST_IDLE;
            end
         end
         ST_SLEEP: begin
            if (attached) begin
               s_nxt.st = ST_IDLE;
               s_nxt.slp = 1'b0;
            end
         end
         default: begin
            s_nxt.st = ST_POR;
         end
      endcase
      s_nxt.drst = supply_lockout;
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b || s_r.drst) begin
         s_r <= '0;
         s_r.st <= ST_POR;
         s_r.cur_mv <= SAFE_MV;
         s_r.comp <= COMP_RST;
         s_r.drst <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // ==================================================================
   // Outputs
   // ==================================================================
   assign vbus_switch_gate = s_r.gate;
   assign discharge_en = s_r.dis;
   assign vconn_en = s_r.vconn;
   assign advertise_en = s_r.adv;
   assign negotiate_en = s_r.neg;
   assign init_start = s_r.init;
   assign hard_reset_req = s_r.hrst;
   assign overtemp_flag = s_r.ot;
   assign sleep_mode = s_r.slp;
   assign device_reset = s_r.drst;
   assign regulation_drive_output = s_r.reg_drv;
   assign ov_thresh_mv = s_r.ovt;
   assign uv_thresh_mv = s_r.uvt;
   assign cable_drop_compensation = s_r.comp;
   // ==================================================================
   // Checks
   // ==================================================================
   ov_gate_off_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) ov_trip && s_r.st == ST_RUN |=> !vbus_switch_gate)
      else $error("gate stayed on after overvoltage");
   ov_discharge_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) ov_trip && s_r.st == ST_RUN |=> discharge_en)
      else $error("no discharge after overvoltage");
   dis_stop_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) discharge_en && at_target |=> !discharge_en)
      else $error("discharge kept past target");
   oc_hard_reset_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) oc_done && s_r.st == ST_RUN |=> hard_reset_req &&
      !vbus_switch_gate) else $error("overcurrent not handled");
   ot_hyst_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) temp_c >= TEMP_W'(OT_SET_C) |=> overtemp_flag)
      else $error("overtemp flag missed");
   cc_uv_off_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) s_r.st == ST_RUN && cc_mode && undervoltage_guard
      |=> !vbus_switch_gate) else $error("cc undervolt kept on");
   lockout_reset_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) supply_lockout |=> ##1 s_r.st == ST_POR)
      else $error("lockout did not reset");
   attach_order_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) $rose(advertise_en) |-> vconn_en && vbus_switch_gate)
      else $error("advertised before power up");
   neg_after_init_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) s_r.st == ST_POR || s_r.st == ST_INIT |-> !negotiate_en)
      else $error("negotiation before init");
endmodule // pfs_seq

// file: verilog/pfs_pkg.sv
// Shared constants for the power sequencer
package pfs_pkg;
   // =====================================================================
   // Clock and tick
   // =====================================================================
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 10;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   // =====================================================================
   // Times in their own units, and derived tick counts
   // =====================================================================
   localparam int OV_OFF_US = 50;
   localparam int OV_OFF_CYC = OV_OFF_US * CLK_MHZ;
   localparam int OV_BLANK_MS = 90;
   localparam int UV_DELAY_MS = 30;
   localparam int OC_DEGLITCH_MS = 30;
   localparam int SC_RESTART_MS = 800;
   localparam int SLEEP_S = 3;
   localparam int OV_BLANK_TK = OV_BLANK_MS * 1000 / TICK_US;
   localparam int UV_DELAY_TK = UV_DELAY_MS * 1000 / TICK_US;
   localparam int OC_DEGLITCH_TK = OC_DEGLITCH_MS * 1000 / TICK_US;
   localparam int SC_RESTART_TK = SC_RESTART_MS * 1000 / TICK_US;
   localparam int SLEEP_TK = SLEEP_S * 1000000 / TICK_US;
   localparam int TKW = 20;
   // =====================================================================
   // Thresholds, temperature, compensation
   // =====================================================================
   localparam int OV_PCT = 120;
   localparam int UV_PCT = 76;
   localparam int OT_SET_C = 140;
   localparam int OT_HYS_C = 25;
   localparam int OT_CLR_C = OT_SET_C - OT_HYS_C;
   localparam int MV_W = 16;
   localparam int TEMP_W = 9;
   localparam int COMP_W = 3;
   localparam logic [MV_W-1:0] SAFE_MV = 16'h1388;
   localparam logic [COMP_W-1:0] COMP_RST = 3'h0;
   localparam logic GATE_ON = 1'b1;
   localparam logic GATE_OFF = 1'b0;
endpackage

// file: verilog/pfs_timer.sv
// Tick-driven qualify timer that restarts when its condition drops
`timescale 1ns/1ps
module pfs_timer
   import pfs_pkg::*;
#(
   parameter int LIMIT = 3000
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic tick,
   input wire logic cond,
   output logic done
);
   typedef struct packed {
      logic [TKW-1:0] cnt;
      logic done;
   } pfs_tmr_t;
   pfs_tmr_t s_r;
   pfs_tmr_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      if (!cond) begin
         s_nxt.cnt = '0;
         s_nxt.done = 1'b0;
      end else if (tick && !s_r.done) begin
         if (s_r.cnt == TKW'(LIMIT - 1)) begin
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign done = s_r.done;
   restart_on_drop_a: assert property (@(posedge core_clk) disable iff
      (!rst_b) !cond |=> !done) else $error("timer held done");
endmodule // pfs_timer

// file: dv/pfs_power_stage.sv
// Behavioural power stage, cable marker and sink beyond the sequencer
`timescale 1ns/1ps
module pfs_power_stage #(
   parameter int CHECK_DLY = 3,
   parameter int DISCH_DLY = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic attach,
   input wire logic flip,
   input wire logic vconn_en,
   input wire logic discharge_en,
   output logic cc1_attached,
   output logic cc2_attached,
   output logic vconn_checked,
   output logic at_target
);
   int vconn_cnt_r;
   int disch_cnt_r;
   // =====================================================================
   // Sink pulls down one CC pin only, chosen by plug orientation
   // =====================================================================
   assign cc1_attached = attach & ~flip;
   assign cc2_attached = attach & flip;
   // Marker answers only while VCONN is powered
   assign vconn_checked = vconn_en && (vconn_cnt_r >= CHECK_DLY);
   // Bus reaches target only after some discharge time
   assign at_target = discharge_en && (disch_cnt_r >= DISCH_DLY);
   always_ff @(posedge core_clk) begin
      if (!rst_b || !vconn_en) begin
         vconn_cnt_r <= 0;
      end else begin
         vconn_cnt_r <= vconn_cnt_r + 1;
      end
      if (!rst_b || !discharge_en) begin
         disch_cnt_r <= 0;
      end else begin
         disch_cnt_r <= disch_cnt_r + 1;
      end
   end
endmodule // pfs_power_stage

// file: dv/testbench.sv
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
module testbench;
   import pfs_pkg::*;
   typedef struct {logic [15:0] mv; logic [2:0] cs;
      logic [15:0] ov; logic [15:0] uv;} pfs_row_t;
   logic core_clk, rst_b, analog_ready, init_done, supply_lockout, attach;
   logic req_valid, ov_cmp, uv_g, oc_g, cc_mode, sc, flip;
   logic [MV_W-1:0] req_mv;
   logic [TEMP_W-1:0] temp_c;
   logic [COMP_W-1:0] comp_set;
   logic cc1, cc2, vchk, at_tgt, gate, dis, vcon, adv, neg, init_st, hr;
   logic ot, slp, drst, rdo;
   logic [MV_W-1:0] ovt, uvt;
   logic [COMP_W-1:0] cdc;
   int n_mismatch = 0;
   int check_count = 0;
   int k;
   pfs_row_t rows[8] = '{
      '{16'h1388, 3'h0, 16'h1770, 16'h0ED8},
      '{16'h2328, 3'h1, 16'h2A30, 16'h1AB8},
      '{16'h2EE0, 3'h2, 16'h3840, 16'h23A0},
      '{16'h2328, 3'h3, 16'h2A30, 16'h1AB8},
      '{16'h2EE0, 3'h4, 16'h3840, 16'h23A0},
      '{16'h1388, 3'h5, 16'h1770, 16'h0ED8},
      '{16'h2EE0, 3'h6, 16'h3840, 16'h23A0},
      '{16'h1388, 3'h7, 16'h1770, 16'h0ED8}};
   pfs_seq #(.OV_BLANK(4), .SC_RESTART(6),
      .SLEEP_DLY(8), .TICK(2)) pfs_seq_i (.core_clk(core_clk),
      .rst_b(rst_b), .analog_ready(analog_ready), .init_done(init_done),
      .supply_lockout(supply_lockout), .cc1_attached(cc1),
      .cc2_attached(cc2), .req_mv(req_mv), .req_valid(req_valid),
      .ov_cmp(ov_cmp), .undervoltage_guard(uv_g),
      .overcurrent_guard(oc_g), .short_cmp(sc), .at_target(at_tgt),
      .cc_mode(cc_mode), .temp_c(temp_c), .comp_set(comp_set),
      .vconn_checked(vchk), .vbus_switch_gate(gate), .discharge_en(dis),
      .vconn_en(vcon), .advertise_en(adv), .negotiate_en(neg),
      .init_start(init_st), .hard_reset_req(hr), .overtemp_flag(ot),
      .sleep_mode(slp), .device_reset(drst),
      .regulation_drive_output(rdo), .ov_thresh_mv(ovt),
      .uv_thresh_mv(uvt), .cable_drop_compensation(cdc));
   pfs_power_stage pfs_power_stage_i (.core_clk(core_clk), .rst_b(rst_b),
      .attach(attach), .flip(flip), .vconn_en(vcon), .discharge_en(dis),
      .cc1_attached(cc1), .cc2_attached(cc2), .vconn_checked(vchk),
      .at_target(at_tgt));
   // =====================================================================
   // Helpers
   // =====================================================================
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_mismatch++;
      finish_test();
   end
   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      {rst_b, analog_ready, init_done, supply_lockout, attach} = '0;
      {req_valid, ov_cmp, uv_g, oc_g, cc_mode, sc, flip} = '0;
      req_mv = 16'h1388;
      temp_c = 9'h019;
      comp_set = 3'h0;
      repeat (6) tick();
      chk(gate, GATE_OFF);
      chk(init_st, 1'b0);
      @(posedge core_clk) rst_b <= 1'b1;
      repeat (3) tick();
      chk(ovt, 16'h1770);
      chk(uvt, 16'h0ED8);
      chk(init_st, 1'b0);
      @(posedge core_clk) analog_ready <= 1'b1;
      for (k = 0; k < 5 && init_st !== 1'b1; k++) tick();
      chk(init_st, 1'b1);
      chk(neg, 1'b0);
      @(posedge core_clk) init_done <= 1'b1;
      foreach (rows[i]) begin
         @(posedge core_clk);
         req_mv <= rows[i].mv;
         comp_set <= rows[i].cs;
         req_valid <= 1'b1;
         @(posedge core_clk) req_valid <= 1'b0;
         repeat (3) tick();
         chk(ovt, rows[i].ov);
         chk(uvt, rows[i].uv);
         chk(16'(cdc), 16'(rows[i].cs));
      end
      repeat (12) tick();
      // Attach bring-up order
      @(posedge core_clk) attach <= 1'b1;
      for (k = 0; k < 5 && gate !== GATE_ON; k++) tick();
      chk(gate, GATE_ON);
      chk(vcon, 1'b0);
      tick();
      chk(vcon, 1'b1);
      chk(adv, 1'b0);
      for (k = 0; k < 10 && adv !== 1'b1; k++) tick();
      chk(adv, 1'b1);
      chk(neg, 1'b1);
      // Overvoltage trip and discharge
      @(posedge core_clk) ov_cmp <= 1'b1;
      for (k = 0; k < 6 && gate !== GATE_OFF; k++) tick();
      chk(gate, GATE_OFF);
      chk(dis, 1'b1);
      @(posedge core_clk) ov_cmp <= 1'b0;
      for (k = 0; k < 20 && dis !== 1'b0; k++) tick();
      chk(dis, 1'b0);
      for (k = 0; k < 30 && adv !== 1'b1; k++) tick();
      chk(adv, 1'b1);
      // Downward step blanks the overvoltage guard
      @(posedge core_clk) {req_mv, req_valid} <= {16'h0FA0, 1'b1};
      @(posedge core_clk) {req_valid, ov_cmp} <= 2'b01;
      repeat (4) @(posedge core_clk);
      ov_cmp <= 1'b0;
      #1;
      chk(gate, GATE_ON);
      // Overcurrent glitch shorter than deglitch, then a real one
      @(posedge core_clk) oc_g <= 1'b1;
      repeat (4) @(posedge core_clk);
      oc_g <= 1'b0;
      repeat (3) tick();
      chk(gate, GATE_ON);
      @(posedge core_clk) oc_g <= 1'b1;
      for (k = 0; k < 6100 && hr !== 1'b1; k++) tick();
      chk(hr, 1'b1);
      chk(16'(k >= 2 * OC_DEGLITCH_TK - 4), 16'h0001);
      tick();
      chk(gate, GATE_OFF);
      chk(hr, 1'b0);
      @(posedge core_clk) oc_g <= 1'b0;
      for (k = 0; k < 30 && adv !== 1'b1; k++) tick();
      // Constant-current fallback hitting undervoltage
      @(posedge core_clk) cc_mode <= 1'b1;
      repeat (2) tick();
      chk(rdo, 1'b1);
      @(posedge core_clk) uv_g <= 1'b1;
      for (k = 0; k < 4 && gate !== GATE_OFF; k++) tick();
      chk(gate, GATE_OFF);
      @(posedge core_clk) {uv_g, cc_mode} <= 2'b00;
      for (k = 0; k < 30 && adv !== 1'b1; k++) tick();
      // Short circuit: off, then paced restart
      @(posedge core_clk) sc <= 1'b1;
      for (k = 0; k < 8 && gate !== GATE_OFF; k++) tick();
      chk(gate, GATE_OFF);
      for (k = 0; k < 40 && gate !== GATE_ON; k++) tick();
      chk(gate, GATE_ON);
      chk(16'(k >= 10), 16'h0001);
      @(posedge core_clk) sc <= 1'b0;
      for (k = 0; k < 30 && adv !== 1'b1; k++) tick();
      // Undervoltage outside CC mode waits its delay
      @(posedge core_clk) uv_g <= 1'b1;
      for (k = 0; k < 6100 && gate !== GATE_OFF; k++) tick();
      chk(gate, GATE_OFF);
      chk(16'(k >= 2 * UV_DELAY_TK - 4), 16'h0001);
      @(posedge core_clk) uv_g <= 1'b0;
      // Overtemperature with hysteresis
      @(posedge core_clk) temp_c <= 9'h08C;
      for (k = 0; k < 5 && ot !== 1'b1; k++) tick();
      chk(ot, 1'b1);
      @(posedge core_clk) temp_c <= 9'h074;
      repeat (4) tick();
      chk(ot, 1'b1);
      @(posedge core_clk) temp_c <= 9'h073;
      for (k = 0; k < 5 && ot !== 1'b0; k++) tick();
      chk(ot, 1'b0);
      // Detach, then sleep
      @(posedge core_clk) attach <= 1'b0;
      for (k = 0; k < 60 && slp !== 1'b1; k++) tick();
      chk(slp, 1'b1);
      // Wake on the other CC pin
      @(posedge core_clk) {attach, flip} <= 2'b11;
      for (k = 0; k < 6 && gate !== GATE_ON; k++) tick();
      chk(slp, 1'b0);
      chk(gate, GATE_ON);
      // Supply lockout; the reset pulse lasts one cycle only
      @(posedge core_clk) supply_lockout <= 1'b1;
      @(posedge core_clk) supply_lockout <= 1'b0;
      #1;
      chk(drst, 1'b1);
      tick();
      chk(drst, 1'b0);
      chk(gate, GATE_OFF);
      chk(init_st, 1'b0);
      finish_test();
   end
endmodule // testbench
